// ==== rtl/lcd_map.vh ====
// Purpose: Constants for the segment LCD scan block
// Assumes: Byte-wide memory-mapped register port, 28-byte display memory
// Notes:   Offsets are byte addresses on the CPU data space
`ifndef LCD_MAP_VH
`define LCD_MAP_VH
`define LCD_MODE_ADDR      16'hff90
`define LCD_MODE_RESET     8'h00
`define LCD_MODE_EN_BIT    7
`define LCD_MODE_SEL_HI    6
`define LCD_MODE_SEL_LO    4
`define LCD_MODE_WMASK     8'hf0
`define LCD_DMEM_FIRST     16'hfa64
`define LCD_DMEM_LAST      16'hfa7f
`define LCD_DMEM_BYTES     28
`define LCD_NUM_SEG        28
`define LCD_NUM_COM        4
`define LCD_NUM_PIX        112
`define LCD_DIV_BASE_LOG2  17
`define LCD_DIV_WIDTH      17
`endif

// ==== rtl/lcd_clk_div.v ====
// Purpose: Frame step enable divider for the LCD scanner
// Assumes: Single clock, shift code 0..3 selects 2^17 down to 2^14
// Notes:   One-cycle pulse; counter keeps running so a code change takes effect at once
`timescale 1ns/1ps
`default_nettype none
module lcd_clk_div #(
  parameter BASE_LOG2 = 17,
  parameter WIDTH     = 17
) (
  input  wire       clk,     // System clock
  input  wire       rstn,    // Async reset, active low
  input  wire [1:0] divSel,  // 0 slowest .. 3 fastest
  output reg        stepEn   // One-cycle frame step pulse
);
  reg  [WIDTH-1:0] count;
  wire [WIDTH-1:0] lastCount;

  // Terminal count is 2^(WIDTH-sel)-1
  assign lastCount = {WIDTH{1'b1}} >> divSel;

  // Free-running counter wraps at the selected terminal count
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count  <= {WIDTH{1'b0}};
      stepEn <= 1'b0;
    end else if (count >= lastCount) begin
      count  <= {WIDTH{1'b0}};
      stepEn <= 1'b1;
    end else begin
      count  <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      stepEn <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/lcd_scan.v ====
// Purpose: Segment LCD scanner with display memory and mode register
// Assumes: Byte CPU port on clk; bit access done by CPU as read-modify-write of the byte
// Notes:   Outputs are logic select levels plus a polarity flag; analog bias lies outside
`timescale 1ns/1ps
`default_nettype none
`include "lcd_map.vh"
module lcd_scan #(
  parameter NUM_SEG = `LCD_NUM_SEG,
  parameter NUM_COM = `LCD_NUM_COM
) (
  input  wire               clk,         // System clock 50 MHz
  input  wire               rstn,        // Async reset, active low
  input  wire [15:0]        cpuAddr,     // CPU byte address
  input  wire [7:0]         cpuWdata,    // CPU write data
  input  wire               cpuWr,       // Write strobe, one cycle
  input  wire               cpuRd,       // Read strobe, one cycle
  output reg  [7:0]         cpuRdata,    // Read data, valid cycle after cpuRd
  input  wire               portByteSel, // Segments 0..7 as port pins when high
  input  wire [NUM_SEG-9:0] portBitSel,  // Segments 8..27 as port pins, one per bit
  output reg  [NUM_COM-1:0] comSelect,   // One-hot active common slot
  output reg                drivePhase,  // Polarity of this frame
  output reg  [NUM_SEG-1:0] segSelect,   // Segment select level per pin
  output reg  [NUM_SEG-1:0] segEnable    // Segment driven by LCD (low: port)
);
  reg  [7:0] lcdModeControl;
  reg  [3:0] dispMem [0:NUM_SEG-1];
  reg  [1:0] comSlot;
  wire       stepEn;
  wire       displayEnable;
  wire [1:0] divSel;
  wire       hitMode;
  wire       hitMem;
  wire [15:0] memOffset;
  wire [4:0] memIdx;
  wire [NUM_SEG-1:0] portMask;
  reg  [NUM_SEG-1:0] next_segSelect;
  integer i;
  integer j;

  assign displayEnable = lcdModeControl[`LCD_MODE_EN_BIT];
  // Top code bit is reserved; only low two bits reach the divider
  assign divSel  = lcdModeControl[`LCD_MODE_SEL_HI-1:`LCD_MODE_SEL_LO];
  assign hitMode = (cpuAddr == `LCD_MODE_ADDR);
  assign hitMem  = (cpuAddr >= `LCD_DMEM_FIRST) && (cpuAddr <= `LCD_DMEM_LAST);
  // Highest address maps to segment 0
  assign memOffset = `LCD_DMEM_LAST - cpuAddr;
  // Only 28 bytes exist, so five offset bits are enough once hitMem holds
  assign memIdx    = memOffset[4:0];
  assign portMask  = {portBitSel, {8{portByteSel}}};

  lcd_clk_div #(
    .BASE_LOG2 (`LCD_DIV_BASE_LOG2),
    .WIDTH     (`LCD_DIV_WIDTH)
  ) u_div (
    .clk    (clk),
    .rstn   (rstn),
    .divSel (divSel),
    .stepEn (stepEn)
  );

  // Mode register; a bit write arrives as a byte read-modify-write
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lcdModeControl <= `LCD_MODE_RESET;
    end else if (cpuWr && hitMode) begin
      lcdModeControl <= cpuWdata & `LCD_MODE_WMASK;
    end
  end

  // Display memory holds low nibble only; cleared at reset
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < NUM_SEG; i = i + 1) begin
        dispMem[i] <= 4'h0;
      end
    end else if (cpuWr && hitMem) begin
      dispMem[memIdx] <= cpuWdata[3:0];
    end
  end

  // Read mux; unmapped addresses read zero
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpuRdata <= 8'h00;
    end else if (cpuRd) begin
      if (hitMode) begin
        cpuRdata <= lcdModeControl;
      end else if (hitMem) begin
        cpuRdata <= {4'h0, dispMem[memIdx]};
      end else begin
        cpuRdata <= 8'h00;
      end
    end
  end

  // Common slot walk and frame polarity toggle at slot 3 wrap
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      comSlot    <= 2'h0;
      drivePhase <= 1'b0;
    end else if (stepEn) begin
      comSlot <= comSlot + 2'h1;
      if (comSlot == 2'h3) begin
        drivePhase <= ~drivePhase;
      end
    end
  end

  // Select bit per segment from memory, forced off when disabled
  always @* begin
    next_segSelect = {NUM_SEG{1'b0}};
    for (j = 0; j < NUM_SEG; j = j + 1) begin
      next_segSelect[j] = displayEnable & dispMem[j][comSlot];
    end
  end

  // Registered pin outputs; commons keep scanning even when display is off
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      comSelect <= {NUM_COM{1'b0}};
      segSelect <= {NUM_SEG{1'b0}};
      segEnable <= {NUM_SEG{1'b0}};
    end else begin
      comSelect <= 4'h1 << comSlot;
      segSelect <= next_segSelect;
      segEnable <= ~portMask;
    end
  end
endmodule
`default_nettype wire

// ==== verif/lcd_scan_monitor.sv ====
// Purpose: Port checker for lcd_scan
// Assumes: Enable bit seen through CPU writes
// Notes: Bound to the scan block
`timescale 1ns/1ps
`default_nettype none
module lcd_scan_monitor (
  input wire logic        clk,         // Clock
  input wire logic        rstn,        // Reset
  input wire logic [15:0] cpuAddr,     // Address
  input wire logic [7:0]  cpuWdata,    // Wdata
  input wire logic        cpuWr,       // Write
  input wire logic        cpuRd,       // Read
  input wire logic [7:0]  cpuRdata,    // Rdata
  input wire logic        portByteSel, // Byte port
  input wire logic [19:0] portBitSel,  // Bit ports
  input wire logic [3:0]  comSelect,   // Commons
  input wire logic        drivePhase,  // Phase
  input wire logic [27:0] segSelect,   // Segments
  input wire logic [27:0] segEnable    // Enables
);
  logic en;
  wire  inMem = cpuAddr >= 16'hfa64 && cpuAddr <= 16'hfa7f;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Enable shadow; bit writes arrive as byte writes, so this stays exact
  always @(posedge clk or negedge rstn)
    if (!rstn) en <= 1'b0;
    else if (cpuWr && cpuAddr == 16'hff90) en <= cpuWdata[7];
  a_com_onehot: assert property ($past(rstn) |-> $onehot(comSelect)) else $error("common not one-hot");
  // Two edges of history so the leap out of the all-zero reset value is not taken as a step
  a_com_order: assert property ($past(rstn, 2) && $changed(comSelect)
    |-> comSelect == (($past(comSelect) << 1) | ($past(comSelect) >> 3))) else $error("common order");
  a_seg_off: assert property (!en && !$past(en) |-> segSelect == 28'h0) else $error("segment on");
  a_byte_port: assert property ($past(rstn) |-> segEnable[7:0] == {8{!$past(portByteSel)}}) else $error("byte port");
  a_bit_port: assert property ($past(rstn) |-> segEnable[27:8] == ~$past(portBitSel)) else $error("bit port");
  a_mode_low: assert property ($past(cpuRd) && $past(cpuAddr) == 16'hff90 |-> cpuRdata[3:0] == 4'h0) else $error("mode");
  a_mem_upper: assert property ($past(cpuRd) && $past(inMem) |-> cpuRdata[7:4] == 4'h0) else $error("memory");
  a_phase_flip: assert property ($past(rstn) && $changed(drivePhase) |-> ##1 comSelect == 4'h1) else $error("phase");
  c_slot3: cover property (comSelect == 4'h8);
  c_flip: cover property ($changed(drivePhase));
  c_lit: cover property (en && segSelect[0]);
endmodule
bind lcd_scan lcd_scan_monitor mon (.clk, .rstn, .cpuAddr, .cpuWdata, .cpuWr, .cpuRd, .cpuRdata, .portByteSel,
  .portBitSel, .comSelect, .drivePhase, .segSelect, .segEnable);
`default_nettype wire

// ==== verif/lcd_glass_model.sv ====
// Purpose: Passive 4 by 28 glass
// Assumes: Pixel lit when its common and driven segment are selected
// Notes: Analog levels not modelled
`timescale 1ns/1ps
`default_nettype none
module lcd_glass_model (
  input wire logic [3:0]   comSelect, // Common
  input wire logic [27:0]  segSelect, // Segments
  input wire logic [27:0]  segEnable, // Driven
  output var logic [111:0] pixOn      // Pixels
);
  // Each row keeps what it saw during its own slot
  always @*
    for (int c = 0; c < 4; c++)
      if (comSelect[c]) pixOn[c*28 +: 28] = segSelect & segEnable;
endmodule
`default_nettype wire

// ==== verif/lcd_segment_common_driver_tb_top.sv ====
// Purpose: Bench for lcd_scan
// Assumes: Code 3, 16384 cycles a step
// Notes: One frame plus a step keeps it short
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_common_driver_tb_top;
  logic clk = 1'b0, rstn = 1'b0, cpuWr = 1'b0, cpuRd = 1'b0, portByteSel = 1'b0, drivePhase;
  logic [15:0] cpuAddr = 16'h0;
  logic [7:0] cpuWdata = 8'h0, cpuRdata;
  logic [19:0] portBitSel = 20'h0;
  logic [3:0] comSelect;
  logic [27:0] segSelect, segEnable;
  logic [111:0] pixOn;
  int n_mismatch = 0, tests_run = 0, t0;
  always #10 clk = ~clk;
  lcd_scan dut (.clk, .rstn, .cpuAddr, .cpuWdata, .cpuWr, .cpuRd, .cpuRdata, .portByteSel, .portBitSel,
    .comSelect, .drivePhase, .segSelect, .segEnable);
  lcd_glass_model glass (.comSelect, .segSelect, .segEnable, .pixOn);
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    {cpuAddr, cpuWdata, cpuWr} <= {a, d, 1'b1};
    @(posedge clk);
    cpuWr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    {cpuAddr, cpuRd} <= {a, 1'b1};
    @(posedge clk);
    cpuRd <= 1'b0;
    @(posedge clk);
    #1 chk(cpuRdata, e);
  endtask
  // Counts edges until the active common moves
  task automatic nextCom(output int dt);
    logic [3:0] c;
    c = comSelect;
    dt = 0;
    while (comSelect === c && dt < 70000) begin
      @(posedge clk);
      #1 dt++;
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(16'hff90, 8'h00);
    wr(16'hfa7f, 8'hf5);
    wr(16'hfa7e, 8'h0a);
    rd(16'hfa7f, 8'h05);
    wr(16'hff90, 8'hbf);
    rd(16'hff90, 8'hb0);
    do nextCom(t0); while (comSelect !== 4'h1);
    chk(drivePhase, 1'b1);
    chk(pixOn[1:0], 2'b01);
    nextCom(t0);
    chk(t0, 16384);
    chk(pixOn[29:28], 2'b10);
    @(posedge clk);
    {portByteSel, portBitSel} <= {1'b1, 20'h1};
    repeat (2) @(posedge clk);
    #1 chk(segEnable, 28'hffffe00);
    wr(16'hff90, 8'h30);
    repeat (3) @(posedge clk);
    #1 chk(segSelect, 28'h0);
    report_and_stop;
  end
  // Watchdog for a stalled scan
  initial begin
    #1900000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
`default_nettype wire
